// ==== tli_interrupt_unit.sv ====
`timescale 1ns/1ns
`include "tli_cfg.svh"

// Overview of operation
// [RL1] secondary register bits 2,1,0 enable interval, supply monitor, serial requests
// [RL2] secondary register bits 6,5,4 pick high level for those three requests
// [RL3] software keeps bit 3 zero; bit 7 is reserved
// [RL4] secondary register resets to A0H
// [RL5] every source is set to exactly one of two levels, low or high
// [RL6] a high request preempts a running low-level service routine
// [RL7] simultaneous high and low requests: high is granted first
// [RL8] a running routine blocks new requests of its own level until return
// [RL9] same-level order: supply monitor, watchdog, external 0, converter, timer 0
// [RL10] then external 1, timer 1, sync serial, async serial, timer 2, interval
// [RL11] on grant the core pushes the program counter before the vector loads
// [RL12] vectors 0003H,000BH,0013H,001BH,0023H,002BH for the first six sources
// [RL13] vectors 0033H,003BH,0043H,0053H,005BH for the remaining sources
// [RL14] a request passes only with its own enable and the global enable set
// [RL15] enabled interval request in power-down wakes the device, vectoring to 0053H
// [RL16] active level recorded on grant, released on return, nested level restored
module tli_interrupt_unit (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_rd,
	output logic      [7:0]  o_sfr_rdata,
	output logic             o_sfr_hit,
	input  wire logic        i_global_irq_enable,
	input  wire logic [7:0]  i_primary_enable,
	input  wire logic [7:0]  i_primary_priority,
	input  wire logic        i_supply_monitor_request,
	input  wire logic        i_watchdog_request,
	input  wire logic        i_external_request_zero,
	input  wire logic        i_converter_done_request,
	input  wire logic        i_timer_zero_overflow,
	input  wire logic        i_external_request_one,
	input  wire logic        i_timer_one_overflow,
	input  wire logic        i_sync_serial_request,
	input  wire logic        i_async_serial_request,
	input  wire logic        i_timer_two_request,
	input  wire logic        i_interval_counter_request,
	input  wire logic        i_boundary,
	input  wire logic        i_push_done,
	input  wire logic        i_reti,
	input  wire logic        i_power_down,
	output logic             o_push_pc,
	output logic             o_load_pc,
	output logic      [15:0] o_vector,
	output logic      [10:0] o_ack_source,
	output logic             o_active_high,
	output logic             o_active_low,
	output logic             o_wake
);
	// secondary register and its named fields
	logic [7:0]  sec_reg;
	logic [7:0]  sec_next;
	wire         sec_sel;
	wire         sec_write;
	wire         interval_irq_enable;
	wire         supply_monitor_irq_enable;
	wire         serial_port_irq_enable;
	wire         interval_irq_priority;
	wire         supply_monitor_irq_priority;
	wire         serial_port_irq_priority;

	// arbitration
	wire  [10:0] raw_req;
	wire  [10:0] src_enable;
	wire  [10:0] src_high;
	wire  [10:0] live_req;
	wire  [10:0] high_req;
	wire  [10:0] low_req;
	wire  [10:0] wake_req;
	wire         wake_event;
	wire         high_found;
	wire         low_found;
	tli_pkg::tli_src_t high_index;
	tli_pkg::tli_src_t low_index;
	wire         grant_high;
	wire         grant_low;
	wire         grant_any;
	tli_pkg::tli_src_t grant_index;

	// control state
	tli_pkg::tli_state_e state_reg;
	tli_pkg::tli_state_e state_next;
	tli_pkg::tli_src_t   winner_reg;
	logic        in_high_reg;
	logic        in_low_reg;
	logic        push_reg;
	logic        load_reg;
	logic [15:0] vector_reg;
	logic [10:0] ack_reg;
	logic [7:0]  rdata_reg;
	logic        hit_reg;
	logic        wake_reg;

	function automatic logic [15:0] vector_of(input tli_pkg::tli_src_t idx);
		logic [15:0] v;
		v = `TLI_VEC_TIC;
		unique case (idx)
			4'(`TLI_SRC_PSM):       v = `TLI_VEC_PSM;       // RL13
			4'(`TLI_SRC_WDT):       v = `TLI_VEC_WDT;       // RL13
			4'(`TLI_SRC_EXT0):      v = `TLI_VEC_EXT0;      // RL12
			4'(`TLI_SRC_ADC):       v = `TLI_VEC_ADC;       // RL13
			4'(`TLI_SRC_TMR0):      v = `TLI_VEC_TMR0;      // RL12
			4'(`TLI_SRC_EXT1):      v = `TLI_VEC_EXT1;      // RL12
			4'(`TLI_SRC_TMR1):      v = `TLI_VEC_TMR1;      // RL12
			4'(`TLI_SRC_SYNC_SER):  v = `TLI_VEC_SYNC_SER;  // RL13
			4'(`TLI_SRC_ASYNC_SER): v = `TLI_VEC_ASYNC_SER; // RL12
			4'(`TLI_SRC_TMR2):      v = `TLI_VEC_TMR2;      // RL12
			4'(`TLI_SRC_TIC):       v = `TLI_VEC_TIC;       // RL13
			default:                v = `TLI_VEC_TIC;
		endcase
		return v;
	endfunction : vector_of

	function automatic logic [10:0] onehot_of(input tli_pkg::tli_src_t idx);
		logic [10:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction : onehot_of

	// register decode
	assign sec_sel   = (i_sfr_addr == `TLI_SEC_ADDR);
	assign sec_write = sec_sel & i_sfr_wr;
	// reserved bit stays at its reset level; bit 3 stores what software writes
	assign sec_next  = sec_write ?
		{sec_reg[`TLI_SEC_RSVD_BIT], i_sfr_wdata[6:0]} : sec_reg; // RL3

	assign interval_irq_enable         = sec_reg[`TLI_SEC_EN_TIC];  // RL1
	assign supply_monitor_irq_enable   = sec_reg[`TLI_SEC_EN_PSM];  // RL1
	assign serial_port_irq_enable      = sec_reg[`TLI_SEC_EN_SER];  // RL1
	assign interval_irq_priority       = sec_reg[`TLI_SEC_PRI_TIC]; // RL2
	assign supply_monitor_irq_priority = sec_reg[`TLI_SEC_PRI_PSM]; // RL2
	assign serial_port_irq_priority    = sec_reg[`TLI_SEC_PRI_SER]; // RL2

	// request vector in polling order
	assign raw_req = {
		i_interval_counter_request,
		i_timer_two_request,
		i_async_serial_request,
		i_sync_serial_request,
		i_timer_one_overflow,
		i_external_request_one,
		i_timer_zero_overflow,
		i_converter_done_request,
		i_external_request_zero,
		i_watchdog_request,
		i_supply_monitor_request
	}; // RL9 RL10

	// primary bits: 0 wdt,1 ext0,2 adc,3 tmr0,4 ext1,5 tmr1,6 async,7 tmr2
	assign src_enable = {
		interval_irq_enable,
		i_primary_enable[7:6],
		serial_port_irq_enable,
		i_primary_enable[5:0],
		supply_monitor_irq_enable
	}; // RL1
	assign src_high = {
		interval_irq_priority,
		i_primary_priority[7:6],
		serial_port_irq_priority,
		i_primary_priority[5:0],
		supply_monitor_irq_priority
	}; // RL5

	assign live_req = raw_req & src_enable & {11{i_global_irq_enable}}; // RL14

	// in power-down only the interval request may wake and be taken
	assign wake_req   = live_req & onehot_of(4'(`TLI_SRC_TIC)); // RL15
	assign wake_event = i_power_down & (|wake_req);             // RL15

	assign high_req = (i_power_down ? wake_req : live_req) & src_high;  // RL5
	assign low_req  = (i_power_down ? wake_req : live_req) & ~src_high; // RL5

	tli_poll_encoder u_poll_high (
		.i_req   (high_req),
		.o_found (high_found),
		.o_index (high_index)
	);

	tli_poll_encoder u_poll_low (
		.i_req   (low_req),
		.o_found (low_found),
		.o_index (low_index)
	);

	// a routine blocks its own level; high blocks everything
	assign grant_high  = high_found & ~in_high_reg;                    // RL6 RL8
	assign grant_low   = low_found & ~in_high_reg & ~in_low_reg & ~high_found; // RL7 RL8
	assign grant_any   = (state_reg == tli_pkg::TLI_IDLE) & i_boundary
		& (grant_high | grant_low);
	assign grant_index = grant_high ? high_index : low_index; // RL7

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			tli_pkg::TLI_IDLE: begin
				if (grant_any) begin
					state_next = tli_pkg::TLI_PUSH;
				end
			end
			tli_pkg::TLI_PUSH: begin
				// vector waits until the core has stacked the pc
				if (i_push_done) begin
					state_next = tli_pkg::TLI_LOAD; // RL11
				end
			end
			tli_pkg::TLI_LOAD: begin
				state_next = tli_pkg::TLI_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sec_reg <= `TLI_SEC_RESET; // RL4
		end else if (i_ce) begin
			sec_reg <= sec_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= '0;
			hit_reg   <= 1'b0;
		end else if (i_ce) begin
			rdata_reg <= (sec_sel & i_sfr_rd) ? sec_reg : 8'h00;
			hit_reg   <= sec_sel & (i_sfr_rd | i_sfr_wr);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg  <= tli_pkg::TLI_IDLE;
			winner_reg <= '0;
		end else if (i_ce) begin
			state_reg <= state_next;
			if (grant_any) begin
				winner_reg <= grant_index;
			end
		end
	end

	// in-service levels; return releases high first, so a nested low resumes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			in_high_reg <= 1'b0;
			in_low_reg  <= 1'b0;
		end else if (i_ce) begin
			if (grant_any & grant_high) begin
				in_high_reg <= 1'b1; // RL16
			end else if (i_reti & in_high_reg) begin
				in_high_reg <= 1'b0; // RL16
			end
			if (grant_any & grant_low) begin
				in_low_reg <= 1'b1; // RL16
			end else if (i_reti & ~in_high_reg) begin
				in_low_reg <= 1'b0; // RL16
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			push_reg   <= 1'b0;
			load_reg   <= 1'b0;
			vector_reg <= '0;
			ack_reg    <= '0;
		end else if (i_ce) begin
			push_reg <= (state_next == tli_pkg::TLI_PUSH); // RL11
			load_reg <= (state_next == tli_pkg::TLI_LOAD); // RL11
			if (state_reg == tli_pkg::TLI_PUSH && i_push_done) begin
				vector_reg <= vector_of(winner_reg); // RL12 RL13
				ack_reg    <= onehot_of(winner_reg);
			end else begin
				ack_reg <= '0;
			end
		end
	end

	// wake is a one-cycle pulse, repeated every other cycle while the unit idles with the wake request live, not a level
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wake_reg <= 1'b0;
		end else if (i_ce) begin
			wake_reg <= wake_event & ~wake_reg & (state_reg == tli_pkg::TLI_IDLE); // RL15
		end
	end

	assign o_sfr_rdata   = rdata_reg;
	assign o_sfr_hit     = hit_reg;
	assign o_push_pc     = push_reg;
	assign o_load_pc     = load_reg;
	assign o_vector      = vector_reg;
	assign o_ack_source  = ack_reg;
	assign o_active_high = in_high_reg;
	assign o_active_low  = in_low_reg;
	assign o_wake        = wake_reg;
endmodule : tli_interrupt_unit

// ==== tli_cfg.svh ====
`ifndef TLI_CFG_SVH
`define TLI_CFG_SVH

// secondary enable/priority register
`define TLI_SEC_ADDR        8'hA9
`define TLI_SEC_RESET       8'hA0
`define TLI_SEC_RSVD_BIT    7
`define TLI_SEC_PRI_TIC     6
`define TLI_SEC_PRI_PSM     5
`define TLI_SEC_PRI_SER     4
`define TLI_SEC_ZERO_BIT    3
`define TLI_SEC_EN_TIC      2
`define TLI_SEC_EN_PSM      1
`define TLI_SEC_EN_SER      0

// source index equals polling rank, index 0 polled first
`define TLI_NUM_SRC         11
`define TLI_SRC_PSM         0
`define TLI_SRC_WDT         1
`define TLI_SRC_EXT0        2
`define TLI_SRC_ADC         3
`define TLI_SRC_TMR0        4
`define TLI_SRC_EXT1        5
`define TLI_SRC_TMR1        6
`define TLI_SRC_SYNC_SER    7
`define TLI_SRC_ASYNC_SER   8
`define TLI_SRC_TMR2        9
`define TLI_SRC_TIC         10

// fixed vectors
`define TLI_VEC_EXT0        16'h0003
`define TLI_VEC_TMR0        16'h000B
`define TLI_VEC_EXT1        16'h0013
`define TLI_VEC_TMR1        16'h001B
`define TLI_VEC_ASYNC_SER   16'h0023
`define TLI_VEC_TMR2        16'h002B
`define TLI_VEC_ADC         16'h0033
`define TLI_VEC_SYNC_SER    16'h003B
`define TLI_VEC_PSM         16'h0043
`define TLI_VEC_TIC         16'h0053
`define TLI_VEC_WDT         16'h005B

`endif

// ==== tli_pkg.sv ====
package tli_pkg;
	typedef logic [3:0] tli_src_t;
	typedef enum logic [1:0] {
		TLI_IDLE,
		TLI_PUSH,
		TLI_LOAD
	} tli_state_e;
endpackage : tli_pkg

// ==== tli_poll_encoder.sv ====
`timescale 1ns/1ns
`include "tli_cfg.svh"

module tli_poll_encoder (
	input  wire logic [`TLI_NUM_SRC-1:0] i_req,
	output logic                         o_found,
	output tli_pkg::tli_src_t            o_index
);
	logic [`TLI_NUM_SRC-1:0] blocked;
	logic [`TLI_NUM_SRC-1:0] first;

	// fixed order: lowest index wins
	assign blocked[0] = 1'b0;
	genvar k;
	generate
		for (k = 1; k < `TLI_NUM_SRC; k++) begin : g_chain
			assign blocked[k] = blocked[k-1] | i_req[k-1];
		end
		for (k = 0; k < `TLI_NUM_SRC; k++) begin : g_first
			assign first[k] = i_req[k] & ~blocked[k];
		end
	endgenerate

	assign o_found = |i_req;

	always_comb begin
		o_index = '0;
		for (int j = 0; j < `TLI_NUM_SRC; j++) begin
			if (first[j]) begin
				o_index = tli_pkg::tli_src_t'(j);
			end
		end
	end
endmodule : tli_poll_encoder

// ==== tli_interrupt_unit_assertions.sv ====
`timescale 1ns/1ns
module tli_interrupt_unit_assertions (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic [7:0]  i_sfr_addr,
	input wire logic        i_sfr_rd,
	input wire logic [7:0]  o_sfr_rdata,
	input wire logic        o_sfr_hit,
	input wire logic        i_global_irq_enable,
	input wire logic        i_boundary,
	input wire logic        i_push_done,
	input wire logic        i_reti,
	input wire logic        i_power_down,
	input wire logic        i_interval_counter_request,
	input wire logic        o_push_pc,
	input wire logic        o_load_pc,
	input wire logic [15:0] o_vector,
	input wire logic [10:0] o_ack_source,
	input wire logic        o_active_high,
	input wire logic        o_active_low,
	input wire logic        o_wake
);
	localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
		16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
	function automatic logic [15:0] vec(input logic [10:0] a);
		vec = 16'hFFFF;
		for (int k = 0; k < 11; k++) if (a[k]) vec = VEC[k];
	endfunction : vec
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// a frozen clock enable holds every register, so steps only count on enabled edges
	sequence s_push_end; o_push_pc && i_push_done && i_ce; endsequence
	sequence s_load; !o_push_pc && o_load_pc ##1 !o_load_pc; endsequence
	a_push_then_load: assert property (s_push_end |=> s_load)
		else $error("load did not follow push");
	a_push_holds: assert property (o_push_pc && !i_push_done |=> o_push_pc)
		else $error("push dropped early");
	a_vector_match: assert property (o_load_pc |-> $onehot(o_ack_source)
		&& o_vector == vec(o_ack_source))
		else $error("vector wrong");
	a_global_gate: assert property ($rose(o_push_pc)
		|-> $past(i_global_irq_enable) && $past(i_boundary))
		else $error("grant without enable");
	a_high_blocks: assert property ($rose(o_push_pc) |-> !$past(o_active_high))
		else $error("grant during high service");
	a_low_preempt: assert property ($rose(o_push_pc) && $past(o_active_low)
		|-> o_active_high)
		else $error("low grant during low service");
	a_reti_low: assert property (i_ce && i_reti && !i_boundary
		&& o_active_low && !o_active_high |=> !o_active_low)
		else $error("low level kept");
	a_sfr_read: assert property (i_ce && i_sfr_rd && i_sfr_addr == 8'hA9 |=> o_sfr_hit)
		else $error("read not answered");
	a_sfr_miss: assert property (i_ce && i_sfr_addr != 8'hA9
		|=> !o_sfr_hit && o_sfr_rdata == 8'h00)
		else $error("unmapped hit");
	a_wake_cause: assert property (o_wake
		|-> $past(i_power_down) && $past(i_interval_counter_request))
		else $error("wake without cause");
endmodule : tli_interrupt_unit_assertions

bind tli_interrupt_unit tli_interrupt_unit_assertions i_chk (
	.i_clk                      (i_clk),
	.i_rst                      (i_rst),
	.i_ce                       (i_ce),
	.i_sfr_addr                 (i_sfr_addr),
	.i_sfr_rd                   (i_sfr_rd),
	.o_sfr_rdata                (o_sfr_rdata),
	.o_sfr_hit                  (o_sfr_hit),
	.i_global_irq_enable        (i_global_irq_enable),
	.i_boundary                 (i_boundary),
	.i_push_done                (i_push_done),
	.i_reti                     (i_reti),
	.i_power_down               (i_power_down),
	.i_interval_counter_request (i_interval_counter_request),
	.o_push_pc                  (o_push_pc),
	.o_load_pc                  (o_load_pc),
	.o_vector                   (o_vector),
	.o_ack_source               (o_ack_source),
	.o_active_high              (o_active_high),
	.o_active_low               (o_active_low),
	.o_wake                     (o_wake)
);

// ==== tli_core_model.sv ====
`timescale 1ns/1ns
module tli_core_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_push_pc,
	input  wire logic [1:0] i_delay,
	output logic            o_push_done
);
	logic [1:0] wait_reg;
	// stack write may be slow, so the bench picks the wait
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_push_pc || o_push_done) begin
			wait_reg    <= 2'h0;
			o_push_done <= 1'b0;
		end else if (wait_reg == i_delay) begin
			o_push_done <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule : tli_core_model

// ==== tli_interrupt_unit_test.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, s) begin \
	compares++; \
	if ((e) !== (s)) begin \
		error_cnt++; \
		$display("BAD %s exp %h got %h", nm, e, s); \
	end \
end
module tli_interrupt_unit_test;
	localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
		16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_ce = 1'b1;
	logic        i_sfr_wr = 1'b0;
	logic        i_sfr_rd = 1'b0;
	logic [7:0]  i_sfr_addr = 8'h00;
	logic [7:0]  i_sfr_wdata = 8'h00;
	logic        i_global_irq_enable = 1'b0;
	logic [7:0]  i_primary_enable = 8'hFF;
	logic [7:0]  i_primary_priority = 8'h00;
	logic [10:0] req = 11'h000;
	logic        i_boundary = 1'b1;
	logic        i_reti = 1'b0;
	logic        i_power_down = 1'b0;
	logic [1:0]  dly = 2'h0;
	logic        i_push_done, o_sfr_hit, o_push_pc, o_load_pc;
	logic        o_active_high, o_active_low, o_wake;
	logic [7:0]  o_sfr_rdata, w, exp_rd[$];
	// monitor keeps its own slot so it never clobbers the stimulus byte
	logic [7:0]  rx;
	logic [15:0] o_vector, v, exp_vec[$];
	logic [10:0] o_ack_source;
	int          error_cnt = 0, compares = 0, wakes = 0;
	tli_interrupt_unit i_tli_interrupt_unit (
		.i_clk                     (i_clk),
		.i_rst                     (i_rst),
		.i_ce                      (i_ce),
		.i_sfr_addr                (i_sfr_addr),
		.i_sfr_wr                  (i_sfr_wr),
		.i_sfr_wdata               (i_sfr_wdata),
		.i_sfr_rd                  (i_sfr_rd),
		.o_sfr_rdata               (o_sfr_rdata),
		.o_sfr_hit                 (o_sfr_hit),
		.i_global_irq_enable       (i_global_irq_enable),
		.i_primary_enable          (i_primary_enable),
		.i_primary_priority        (i_primary_priority),
		.i_supply_monitor_request  (req[0]),
		.i_watchdog_request        (req[1]),
		.i_external_request_zero   (req[2]),
		.i_converter_done_request  (req[3]),
		.i_timer_zero_overflow     (req[4]),
		.i_external_request_one    (req[5]),
		.i_timer_one_overflow      (req[6]),
		.i_sync_serial_request     (req[7]),
		.i_async_serial_request    (req[8]),
		.i_timer_two_request       (req[9]),
		.i_interval_counter_request(req[10]),
		.i_boundary                (i_boundary),
		.i_push_done               (i_push_done),
		.i_reti                    (i_reti),
		.i_power_down              (i_power_down),
		.o_push_pc                 (o_push_pc),
		.o_load_pc                 (o_load_pc),
		.o_vector                  (o_vector),
		.o_ack_source              (o_ack_source),
		.o_active_high             (o_active_high),
		.o_active_low              (o_active_low),
		.o_wake                    (o_wake)
	);
	tli_core_model i_tli_core_model (.i_clk(i_clk), .i_rst(i_rst), .i_push_pc(o_push_pc),
		.i_delay(dly), .o_push_done(i_push_done));
	initial forever #50 i_clk = ~i_clk;
	// sampled before the edge's updates land, so values are those of the ending cycle
	always @(posedge i_clk) begin
		if (o_load_pc === 1'b1) begin
			v = exp_vec.size() ? exp_vec.pop_front() : 16'hFFFF;
			`CHK("vector", v, o_vector)
			req <= req & ~o_ack_source;
		end
		if (o_sfr_hit === 1'b1) begin
			rx = exp_rd.size() ? exp_rd.pop_front() : 8'hEE;
			`CHK("rdata", rx, o_sfr_rdata)
		end
		if (o_wake === 1'b1) wakes++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wr = wr;
		i_sfr_rd = !wr;
		i_sfr_wdata = d;
		if (a == 8'hA9) exp_rd.push_back(wr ? 8'h00 : d);
		tick(1);
		i_sfr_wr = 1'b0;
		i_sfr_rd = 1'b0;
		i_sfr_addr = 8'h00;
		tick(1);
	endtask : sfr
	task automatic wait_load;
		dly = 2'($urandom());
		for (int k = 0; k < 60 && o_load_pc !== 1'b1; k++) tick(1);
		tick(1);
	endtask : wait_load
	task automatic retn;
		i_boundary = 1'b0;
		i_reti = 1'b1;
		tick(1);
		i_boundary = 1'b1;
		i_reti = 1'b0;
	endtask : retn
	task automatic serve;
		wait_load();
		retn();
	endtask : serve
	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask : fin
	task automatic print_verdict;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	initial begin
		#500000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		w = 8'($urandom(32'h83b7));
		tick(8);
		i_rst = 1'b0;
		tick(1);
		sfr(1'b0, 8'hA9, 8'hA0);
		sfr(1'b0, 8'hA8, 8'h00);
		w = 8'($urandom()) & 8'h77;
		sfr(1'b1, 8'hA9, w);
		sfr(1'b0, 8'hA9, w | 8'h80);
		sfr(1'b1, 8'hA9, 8'h07);
		fin("register");
		i_global_irq_enable = 1'b1;
		for (int k = 0; k < 11; k++) exp_vec.push_back(VEC[k]);
		req = 11'h7FF;
		repeat (11) serve();
		fin("polling");
		i_global_irq_enable = 1'b0;
		req[4] = 1'b1;
		tick(20);
		i_primary_enable = 8'hF7;
		i_global_irq_enable = 1'b1;
		tick(20);
		exp_vec.push_back(16'h000B);
		i_primary_enable = 8'hFF;
		serve();
		fin("gating");
		// clock enable low must freeze arbitration with a live request waiting
		i_ce = 1'b0;
		exp_vec.push_back(16'h000B);
		req[4] = 1'b1;
		tick(5);
		`CHK("frozen", 1'b0, o_push_pc)
		i_ce = 1'b1;
		serve();
		fin("freeze");
		exp_vec.push_back(16'h0013);
		exp_vec.push_back(16'h000B);
		req[5] = 1'b1;
		wait_load();
		i_primary_priority = 8'h08;
		req[4] = 1'b1;
		wait_load();
		`CHK("nest", 2'b11, {o_active_high, o_active_low})
		retn();
		`CHK("unnest", 2'b01, {o_active_high, o_active_low})
		retn();
		`CHK("idle", 2'b00, {o_active_high, o_active_low})
		i_primary_priority = 8'h00;
		fin("preempt");
		sfr(1'b1, 8'hA9, 8'h47);
		exp_vec.push_back(16'h0053);
		exp_vec.push_back(16'h0043);
		req = 11'h401;
		wait_load();
		`CHK("level", 2'b10, {o_active_high, o_active_low})
		tick(10);
		retn();
		serve();
		fin("levels");
		i_power_down = 1'b1;
		exp_vec.push_back(16'h0053);
		req[10] = 1'b1;
		serve();
		`CHK("wake", 1, wakes)
		i_power_down = 1'b0;
		fin("wake");
		`CHK("pending", 0, exp_vec.size() + exp_rd.size())
		print_verdict();
	end
endmodule : tli_interrupt_unit_test
